/* shared/bitc_pkg.sv */
// constants shared by the banked I/O window and the transmit control logic
// assumes one 200 MHz controller clock and a synchronous active-low reset
package bitc_pkg;
  // clock figure, kept for derived timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // window geometry: sixteen byte locations, eight words
  localparam int unsigned WINDOW_BYTES = 16;
  localparam logic [2:0] IDX_TX_CONTROL = 3'h0; // byte offset 0x0
  localparam logic [2:0] IDX_BANK_SELECT = 3'h7; // byte offset 0xE, seen from every bank
  // bank field
  localparam logic [2:0] BANK_RESET = 3'h0;
  localparam logic [2:0] BANK_LAST = 3'h4; // five banks, 0 to 4
  localparam logic [2:0] BANK_TX = 3'h0;
  // arbitrary signature byte, not tied to any product
  localparam logic [7:0] SIGNATURE_DEFAULT = 8'hA5;
  // transmit control word
  localparam logic [15:0] TCR_RESET = 16'h0000;
  localparam logic [15:0] TCR_WRITE_MASK = 16'hFD8F; // undefined bits read zero
  localparam int unsigned TXEN_BIT = 0;
  localparam int unsigned LOOP_BIT = 1;
  localparam int unsigned FORCE_COLLISION_BIT = 2;
  localparam int unsigned TXPEND_BIT = 3;
  localparam int unsigned PAD_BIT = 7;
  localparam int unsigned CRC_SUPPRESS_BIT = 8;
  localparam int unsigned CARMON_BIT = 10;
  localparam int unsigned FDUP_BIT = 11;
  localparam int unsigned SQESTOP_BIT = 12;
  localparam int unsigned PHYLOOP_BIT = 13;
  localparam int unsigned ETTYPE_BIT = 14;
  localparam int unsigned SWITCHED_FULL_DUPLEX_BIT = 15;
  // early transmit comparison widths
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned PKT_W = 6;
  // host pin bundle: {rdN, wrN, be0N, be1N, wide, addr[3:0], data[15:0]}
  localparam int unsigned BUS_SYNC_W = 25;
  localparam logic [24:0] BUS_SYNC_RESET = 25'h1E00000; // strobes idle high
  // host access sequencing
  typedef enum logic [1:0] {
    BusIdle,
    BusRead,
    BusWrite
  } bitc_bus_e;
endpackage : bitc_pkg

/* hw/bitc_sync2.sv */
// two-stage synchroniser for host pins entering the controller clock
// assumes inputs are quasi-static around strobes; reset value is a constant
`timescale 1ns/1ps
module bitc_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // first stage, read only by the second
  logic [WIDTH-1:0] stage1_q;

  // both stages take the idle pattern on reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stage1_q <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1_q <= din;
      dout <= stage1_q;
    end
  end
endmodule : bitc_sync2

/* hw/bitc_tx_modes.sv */
// effective transmit modes derived from the control word
// purely combinational; the top module registers every result
`timescale 1ns/1ps
module bitc_tx_modes (
  input wire logic [15:0] tcrWord,
  input wire logic earlyTxEnable,
  input wire logic [bitc_pkg::ADDR_W-1:0] txDmaAddr,
  input wire logic [bitc_pkg::ADDR_W-1:0] hostPointerAddr,
  input wire logic [bitc_pkg::PKT_W-1:0] loadPktNum,
  input wire logic [bitc_pkg::PKT_W-1:0] txPktNum,
  input wire logic [bitc_pkg::ADDR_W-1:0] loadAddr,
  input wire logic [bitc_pkg::ADDR_W-1:0] txLogicalAddr,
  output logic fullDuplexEff,
  output logic carrierMonEff,
  output logic deferEnable,
  output logic collisionDetectEnable,
  output logic netTxEnable,
  output logic forceUnderrun
);
  logic switched; // switched full duplex
  logic anyLoop; // either loopback point active

  always_comb begin
    switched = tcrWord[bitc_pkg::SWITCHED_FULL_DUPLEX_BIT];
    anyLoop = tcrWord[bitc_pkg::PHYLOOP_BIT] | tcrWord[bitc_pkg::LOOP_BIT];
    // switched mode overrides the duplex and carrier bits
    fullDuplexEff = switched | tcrWord[bitc_pkg::FDUP_BIT];
    carrierMonEff = ~switched & tcrWord[bitc_pkg::CARMON_BIT];
    // forced collision works by skipping deferral
    deferEnable = ~switched & ~tcrWord[bitc_pkg::FORCE_COLLISION_BIT];
    // collision sense ignored when switched or looped locally
    collisionDetectEnable = ~switched & ~tcrWord[bitc_pkg::LOOP_BIT];
    // no wire traffic during either loopback
    netTxEnable = ~anyLoop;
    // underrun forcing, method chosen by the early transmit type bit
    if (!earlyTxEnable) begin
      forceUnderrun = 1'b0;
    end else if (!tcrWord[bitc_pkg::ETTYPE_BIT]) begin
      forceUnderrun = txDmaAddr > hostPointerAddr;
    end else begin
      forceUnderrun = (loadPktNum == txPktNum) && (txLogicalAddr > loadAddr);
    end
  end
endmodule : bitc_tx_modes

/* hw/bitc_io_tx_control.sv */
// banked host I/O window with the transmit control word
// host pins are asynchronous and pass two flops; engine signals share mclk
`timescale 1ns/1ps
// Operation
// - sixteen-byte window, bank word in every bank
// - offset addresses even byte; odd byte is plus one
// - sixteen-bit mode takes word and byte accesses
// - three-bit bank field, codes 5-7 select nothing
// - bank word upper byte returns fixed signature
// - bank word reachable except in power-down
// - missing banks ignore writes, read signature byte
// - hard reset clears control bits, bank zero
// - crc suppress bit stops frame check append
// - switched mode forces duplex, disables carrier monitor
// - method zero forces underrun past host pointer
// - method one compares packet numbers and addresses
// - phy loopback; exit needs soft reset
// - sqe failure stops transmitter when enabled
// - duplex decides whether own frames are received
// - carrier monitor aborts without crc, disables
// - padding to sixty-four bytes with zeros
// - force collision skips deferral, self clears
// - local loopback after encoder, nothing to network
// - error stops clear transmit enable
module bitc_io_tx_control #(
  parameter logic [7:0] SIGNATURE = bitc_pkg::SIGNATURE_DEFAULT // arbitrary value
) (
  input wire logic mclk,
  input wire logic nrst,
  // host pins
  input wire logic [3:0] ioAddr,
  input wire logic [15:0] ioDataIn,
  output logic [15:0] ioDataOut,
  output logic ioDataOe,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic ioByteEn0N,
  input wire logic ioByteEn1N,
  input wire logic wideBusMode,
  // configuration side, same clock
  input wire logic powerDown,
  input wire logic configSoftReset,
  // transmit engine, same clock
  input wire logic frameActive,
  input wire logic preambleDone,
  input wire logic carrierSense,
  input wire logic collisionSeen,
  input wire logic sqeTestFail,
  input wire logic txFatalError,
  input wire logic earlyTxEnable,
  input wire logic [bitc_pkg::ADDR_W-1:0] txDmaAddr,
  input wire logic [bitc_pkg::ADDR_W-1:0] hostPointerAddr,
  input wire logic [bitc_pkg::PKT_W-1:0] loadPktNum,
  input wire logic [bitc_pkg::PKT_W-1:0] txPktNum,
  input wire logic [bitc_pkg::ADDR_W-1:0] loadAddr,
  input wire logic [bitc_pkg::ADDR_W-1:0] txLogicalAddr,
  // transmit controls
  output logic txStartAllowed,
  output logic crcAppend,
  output logic padEnable,
  output logic fullDuplexEff,
  output logic carrierMonEff,
  output logic deferEnable,
  output logic collisionDetectEnable,
  output logic acceptOwnFrames,
  output logic phyLoopback,
  output logic localLoopback,
  output logic netTxEnable,
  output logic forceUnderrun,
  output logic frameAbortNoCrc,
  output logic txHalt,
  output logic loopResetNeeded
);
  // synchronised pins
  logic [bitc_pkg::BUS_SYNC_W-1:0] syncBus;
  logic syncRdN; // read strobe, active low
  logic syncWrN; // write strobe, active low
  logic syncBe0N; // low lane enable, active low
  logic syncBe1N; // high lane enable, active low
  logic syncWide; // sixteen-bit mode
  logic [3:0] syncAddr;
  logic [15:0] syncData;
  // access sequencing
  bitc_pkg::bitc_bus_e busState_q;
  bitc_pkg::bitc_bus_e busState_d;
  logic [3:0] capAddr_q; // write address held while strobe low
  logic [15:0] capData_q; // write data held while strobe low
  logic [1:0] capLanes_q; // write lanes held while strobe low
  logic commit; // write completes on strobe release
  // register state
  logic [15:0] tcr_q;
  logic [15:0] tcr_d;
  logic [2:0] bank_q;
  logic bankValid;
  logic [15:0] readWord;
  logic [1:0] rdLanes;
  logic [7:0] loByte;
  logic [7:0] hiByte;
  logic wrTcrLo;
  logic wrTcrHi;
  logic wrBank;
  // transmit event logic
  logic pastPreamble_q;
  logic carrierFault;
  logic sqeStop;
  logic errorStop;
  logic phyLoopPrev_q;
  // mode results
  logic modeFullDuplex;
  logic modeCarrierMon;
  logic modeDefer;
  logic modeCollision;
  logic modeNetTx;
  logic modeUnderrun;

  // byte lanes touched by an access; shared by read and write paths
  function automatic logic [1:0] laneSel(input logic a0, input logic be0N,
                                         input logic be1N, input logic wide);
    if (wide) begin
      laneSel = {~be1N, ~be0N};
    end else begin
      laneSel = a0 ? 2'b10 : 2'b01;
    end
  endfunction : laneSel

  bitc_sync2 #(
    .WIDTH(bitc_pkg::BUS_SYNC_W),
    .RESET_VAL(bitc_pkg::BUS_SYNC_RESET)
  ) u_pinSync (
    .mclk(mclk),
    .nrst(nrst),
    .din({ioRdN, ioWrN, ioByteEn0N, ioByteEn1N, wideBusMode, ioAddr, ioDataIn}),
    .dout(syncBus)
  );

  assign {syncRdN, syncWrN, syncBe0N, syncBe1N, syncWide, syncAddr, syncData} = syncBus;

  bitc_tx_modes u_modes (
    .tcrWord(tcr_q),
    .earlyTxEnable(earlyTxEnable),
    .txDmaAddr(txDmaAddr),
    .hostPointerAddr(hostPointerAddr),
    .loadPktNum(loadPktNum),
    .txPktNum(txPktNum),
    .loadAddr(loadAddr),
    .txLogicalAddr(txLogicalAddr),
    .fullDuplexEff(modeFullDuplex),
    .carrierMonEff(modeCarrierMon),
    .deferEnable(modeDefer),
    .collisionDetectEnable(modeCollision),
    .netTxEnable(modeNetTx),
    .forceUnderrun(modeUnderrun)
  );

  // next access state; power-down blocks every access
  always_comb begin
    busState_d = busState_q;
    case (busState_q)
      bitc_pkg::BusIdle: begin
        if (!syncRdN && !powerDown) begin
          busState_d = bitc_pkg::BusRead;
        end else if (!syncWrN && !powerDown) begin
          busState_d = bitc_pkg::BusWrite;
        end
      end
      bitc_pkg::BusRead: begin
        if (syncRdN || powerDown) begin
          busState_d = bitc_pkg::BusIdle;
        end
      end
      default: begin
        if (syncWrN) begin
          busState_d = bitc_pkg::BusIdle;
        end
      end
    endcase
  end

  // access state register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busState_q <= bitc_pkg::BusIdle;
    end else begin
      busState_q <= busState_d;
    end
  end

  // hold address and data while the write strobe is low;
  // data is taken on release so late-settling data is still caught
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      capAddr_q <= 4'h0;
      capData_q <= 16'h0000;
      capLanes_q <= 2'h0;
    end else if (!syncWrN) begin
      capAddr_q <= syncAddr;
      capData_q <= syncData;
      capLanes_q <= laneSel(syncAddr[0], syncBe0N, syncBe1N, syncWide);
    end
  end

  // write decode; the word index drops the byte address bit
  always_comb begin
    commit = (busState_q == bitc_pkg::BusWrite) && syncWrN && !powerDown;
    bankValid = bank_q <= bitc_pkg::BANK_LAST;
    loByte = capData_q[7:0];
    // eight-bit hosts put the odd byte on the low data lines
    hiByte = syncWide ? capData_q[15:8] : capData_q[7:0];
    // bank word decoded ahead of the bank check: present in every bank
    wrBank = 1'b0;
    wrTcrLo = 1'b0;
    wrTcrHi = 1'b0;
    if (commit && capAddr_q[3:1] == bitc_pkg::IDX_BANK_SELECT) begin
      wrBank = capLanes_q[0];
    end else if (commit && !bankValid) begin
      wrBank = 1'b0;
    end else if (commit && bank_q == bitc_pkg::BANK_TX
                 && capAddr_q[3:1] == bitc_pkg::IDX_TX_CONTROL) begin
      wrTcrLo = capLanes_q[0];
      wrTcrHi = capLanes_q[1];
    end
  end

  // read data for the addressed word
  always_comb begin
    rdLanes = laneSel(syncAddr[0], syncBe0N, syncBe1N, syncWide);
    if (syncAddr[3:1] == bitc_pkg::IDX_BANK_SELECT) begin
      readWord = {SIGNATURE, 5'h00, bank_q};
    end else if (!bankValid) begin
      readWord = {SIGNATURE, SIGNATURE};
    end else if (bank_q == bitc_pkg::BANK_TX && syncAddr[3:1] == bitc_pkg::IDX_TX_CONTROL) begin
      readWord = tcr_q;
    end else begin
      readWord = 16'h0000; // registers held elsewhere
    end
  end

  // read drivers; an odd byte in eight-bit mode moves to the low lines
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ioDataOut <= 16'h0000;
      ioDataOe <= 1'b0;
    end else begin
      ioDataOe <= busState_d == bitc_pkg::BusRead;
      if (!syncWide && rdLanes[1]) begin
        ioDataOut <= {8'h00, readWord[15:8]};
      end else begin
        ioDataOut <= readWord;
      end
    end
  end

  // bank field; only the low three bits store
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bank_q <= bitc_pkg::BANK_RESET;
    end else if (wrBank) begin
      bank_q <= loByte[2:0];
    end
  end

  // transmit event decode
  always_comb begin
    // carrier must be up at preamble end and stay up
    carrierFault = modeCarrierMon && frameActive && !carrierSense
                   && (preambleDone || pastPreamble_q);
    // no test window in switched mode
    sqeStop = sqeTestFail && tcr_q[bitc_pkg::SQESTOP_BIT]
              && !tcr_q[bitc_pkg::SWITCHED_FULL_DUPLEX_BIT];
    errorStop = txFatalError || sqeStop || carrierFault;
  end

  // control word next value; a host write of one beats a hardware clear
  always_comb begin
    tcr_d = tcr_q;
    if (wrTcrLo) begin
      tcr_d[7:0] = loByte & bitc_pkg::TCR_WRITE_MASK[7:0];
    end
    if (wrTcrHi) begin
      tcr_d[15:8] = hiByte & bitc_pkg::TCR_WRITE_MASK[15:8];
    end
    if (errorStop && !(wrTcrLo && loByte[bitc_pkg::TXEN_BIT])) begin
      tcr_d[bitc_pkg::TXEN_BIT] = 1'b0;
    end
    if (collisionSeen && !(wrTcrLo && loByte[bitc_pkg::FORCE_COLLISION_BIT])) begin
      tcr_d[bitc_pkg::FORCE_COLLISION_BIT] = 1'b0;
    end
  end

  // control word register; soft reset restores defaults too
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tcr_q <= bitc_pkg::TCR_RESET;
    end else if (configSoftReset) begin
      tcr_q <= bitc_pkg::TCR_RESET;
    end else begin
      tcr_q <= tcr_d;
    end
  end

  // preamble tracker, ended by the frame's own signal
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pastPreamble_q <= 1'b0;
    end else if (!frameActive) begin
      pastPreamble_q <= 1'b0;
    end else if (preambleDone) begin
      pastPreamble_q <= 1'b1;
    end
  end

  // loopback exit leaves state that only a soft or hard reset clears
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phyLoopPrev_q <= 1'b0;
      loopResetNeeded <= 1'b0;
    end else begin
      phyLoopPrev_q <= tcr_q[bitc_pkg::PHYLOOP_BIT];
      if (phyLoopPrev_q && !tcr_q[bitc_pkg::PHYLOOP_BIT]) begin
        loopResetNeeded <= 1'b1;
      end else if (configSoftReset) begin
        loopResetNeeded <= 1'b0;
      end
    end
  end

  // registered transmit controls
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      txStartAllowed <= 1'b0;
      crcAppend <= 1'b1;
      padEnable <= 1'b0;
      fullDuplexEff <= 1'b0;
      carrierMonEff <= 1'b0;
      deferEnable <= 1'b1;
      collisionDetectEnable <= 1'b1;
      acceptOwnFrames <= 1'b0;
      phyLoopback <= 1'b0;
      localLoopback <= 1'b0;
      netTxEnable <= 1'b1;
      forceUnderrun <= 1'b0;
      frameAbortNoCrc <= 1'b0;
      txHalt <= 1'b0;
    end else begin
      // engine finishes a running frame; this only gates new starts
      txStartAllowed <= tcr_q[bitc_pkg::TXEN_BIT] && !loopResetNeeded;
      crcAppend <= !tcr_q[bitc_pkg::CRC_SUPPRESS_BIT];
      padEnable <= tcr_q[bitc_pkg::PAD_BIT];
      fullDuplexEff <= modeFullDuplex;
      carrierMonEff <= modeCarrierMon;
      deferEnable <= modeDefer;
      collisionDetectEnable <= modeCollision;
      acceptOwnFrames <= modeFullDuplex;
      phyLoopback <= tcr_q[bitc_pkg::PHYLOOP_BIT];
      localLoopback <= tcr_q[bitc_pkg::LOOP_BIT];
      netTxEnable <= modeNetTx;
      forceUnderrun <= modeUnderrun;
      frameAbortNoCrc <= carrierFault;
      txHalt <= errorStop;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  reset_defaults_a: assert property (disable iff (1'b0) !nrst |=>
      (tcr_q == bitc_pkg::TCR_RESET && bank_q == bitc_pkg::BANK_RESET))
    else $error("control state not at defaults after reset");
  bank_write_a: assert property (wrBank |=> bank_q == $past(loByte[2:0]))
    else $error("bank field did not take written code");
  signature_read_a: assert property ((busState_d == bitc_pkg::BusRead
      && syncAddr[3:1] == bitc_pkg::IDX_BANK_SELECT && syncWide)
      |=> ioDataOut[15:8] == SIGNATURE && ioDataOe)
    else $error("bank word upper byte not signature");
  dead_bank_a: assert property ((commit && !bankValid && !errorStop
      && !collisionSeen && !configSoftReset) |=> $stable(tcr_q))
    else $error("write landed in a missing bank");
  power_down_a: assert property (powerDown [*2] |-> !ioDataOe)
    else $error("data driven during power-down");
  byte_lane_a: assert property ((wrTcrLo && !wrTcrHi && !configSoftReset)
      |=> tcr_q[15:8] == $past(tcr_q[15:8]))
    else $error("byte write disturbed other lane");
  switched_mode_a: assert property (tcr_q[bitc_pkg::SWITCHED_FULL_DUPLEX_BIT]
      |=> fullDuplexEff && !carrierMonEff && acceptOwnFrames)
    else $error("switched mode did not force duplex");
  sqe_stop_a: assert property ((sqeStop && !(wrTcrLo && loByte[bitc_pkg::TXEN_BIT])
      && !configSoftReset) |=> !tcr_q[bitc_pkg::TXEN_BIT] && txHalt ##1 !txStartAllowed)
    else $error("sqe failure did not stop transmitter");
  carrier_abort_a: assert property (carrierFault |=> frameAbortNoCrc ##1
      !txStartAllowed)
    else $error("carrier loss did not abort");
  crc_suppress_a: assert property ($rose(tcr_q[bitc_pkg::CRC_SUPPRESS_BIT]) |=> !crcAppend)
    else $error("crc still appended when suppressed");
  local_loop_a: assert property (tcr_q[bitc_pkg::LOOP_BIT] |=>
      !netTxEnable && !collisionDetectEnable)
    else $error("local loopback reached the network");
  collision_clear_a: assert property ((collisionSeen && tcr_q[bitc_pkg::FORCE_COLLISION_BIT]
      && !wrTcrLo) |=> !tcr_q[bitc_pkg::FORCE_COLLISION_BIT] ##1 deferEnable == !tcr_q[bitc_pkg::SWITCHED_FULL_DUPLEX_BIT])
    else $error("force collision did not self clear");
endmodule : bitc_io_tx_control

/* tb/bitc_host_model.sv */
// host processor model: drives the banked window pins one access at a time
// assumes the bench clock; pins move only at the falling edge
`timescale 1ns/1ps
module bitc_host_model (
  input wire logic mclk,
  output logic [3:0] ioAddr,
  output logic [15:0] ioDataIn,
  input wire logic [15:0] ioDataOut,
  input wire logic ioDataOe,
  output logic ioRdN,
  output logic ioWrN,
  output logic ioByteEn0N,
  output logic ioByteEn1N,
  output logic wideBusMode
);
  // strobes idle high from time zero
  initial begin
    ioAddr = 4'h0;
    ioDataIn = 16'h0000;
    {ioRdN, ioWrN, ioByteEn0N, ioByteEn1N} = 4'hF;
    wideBusMode = 1'b1;
  end

  // one access; a read waits for the data enable, bounded to eight cycles
  task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d,
                        input logic [1:0] be, input logic wide,
                        output logic [15:0] q, output logic ok);
    int n;
    n = 0;
    q = 16'h0000;
    ok = wr;
    @(negedge mclk);
    ioAddr = a;
    // reserved pending bit of the control word always goes out as zero
    ioDataIn = (wr && a[3:1] == 3'h0 && (wide || !a[0])) ? (d & 16'hFFF7) : d;
    {ioByteEn1N, ioByteEn0N} = ~be;
    wideBusMode = wide;
    if (wr) ioWrN = 1'b0;
    else ioRdN = 1'b0;
    while (n < 8 && (wr ? n < 4 : ioDataOe !== 1'b1)) begin
      @(negedge mclk);
      n++;
    end
    // data is taken at the edge where the enable is seen
    if (!wr && ioDataOe === 1'b1) begin
      q = ioDataOut;
      ok = 1'b1;
    end
    ioRdN = 1'b1;
    ioWrN = 1'b1;
    // address and data held while the pin synchronisers drain
    repeat (4) @(negedge mclk);
    // released lines no longer show the last word
    ioDataIn = ~ioDataIn;
    repeat (4) @(negedge mclk);
  endtask : access
endmodule : bitc_host_model

/* tb/banked_io_tx_control_tb.sv */
// self-checking bench for the banked window and transmit control word
// assumes the host model drives every host pin; engine pins come from here
`timescale 1ns/1ps
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin errors++; \
  $display("Error at %0t ns: got %h, expected %h", $time, (a), (e)); end end
module banked_io_tx_control_tb;
  localparam logic [7:0] SIG = bitc_pkg::SIGNATURE_DEFAULT; // arbitrary value
  logic mclk, nrst, ioDataOe, ioRdN, ioWrN, ioByteEn0N, ioByteEn1N, wideBusMode;
  logic [3:0] ioAddr;
  logic [15:0] ioDataIn, ioDataOut, rdata;
  logic powerDown, configSoftReset, frameActive, preambleDone, carrierSense, ok, seen;
  logic collisionSeen, sqeTestFail, txFatalError, earlyTxEnable;
  logic [bitc_pkg::ADDR_W-1:0] txDmaAddr, hostPointerAddr, loadAddr, txLogicalAddr;
  logic [bitc_pkg::PKT_W-1:0] loadPktNum, txPktNum;
  logic txStartAllowed, crcAppend, padEnable, fullDuplexEff, carrierMonEff, deferEnable;
  logic collisionDetectEnable, acceptOwnFrames, phyLoopback, localLoopback, netTxEnable;
  logic forceUnderrun, frameAbortNoCrc, txHalt, loopResetNeeded;
  int errors = 0; // mismatches
  int nTests = 0; // comparisons made

  bitc_io_tx_control bitc_io_tx_control_inst (.mclk(mclk), .nrst(nrst), .ioAddr(ioAddr),
    .ioDataIn(ioDataIn), .ioDataOut(ioDataOut), .ioDataOe(ioDataOe), .ioRdN(ioRdN),
    .ioWrN(ioWrN), .ioByteEn0N(ioByteEn0N), .ioByteEn1N(ioByteEn1N),
    .wideBusMode(wideBusMode), .powerDown(powerDown), .configSoftReset(configSoftReset),
    .frameActive(frameActive), .preambleDone(preambleDone), .carrierSense(carrierSense),
    .collisionSeen(collisionSeen), .sqeTestFail(sqeTestFail), .txFatalError(txFatalError),
    .earlyTxEnable(earlyTxEnable), .txDmaAddr(txDmaAddr), .hostPointerAddr(hostPointerAddr),
    .loadPktNum(loadPktNum), .txPktNum(txPktNum), .loadAddr(loadAddr),
    .txLogicalAddr(txLogicalAddr), .txStartAllowed(txStartAllowed), .crcAppend(crcAppend),
    .padEnable(padEnable), .fullDuplexEff(fullDuplexEff), .carrierMonEff(carrierMonEff),
    .deferEnable(deferEnable), .collisionDetectEnable(collisionDetectEnable),
    .acceptOwnFrames(acceptOwnFrames), .phyLoopback(phyLoopback),
    .localLoopback(localLoopback), .netTxEnable(netTxEnable), .forceUnderrun(forceUnderrun),
    .frameAbortNoCrc(frameAbortNoCrc), .txHalt(txHalt), .loopResetNeeded(loopResetNeeded));
  bitc_host_model bitc_host_model_inst (.mclk(mclk), .ioAddr(ioAddr), .ioDataIn(ioDataIn),
    .ioDataOut(ioDataOut), .ioDataOe(ioDataOe), .ioRdN(ioRdN), .ioWrN(ioWrN),
    .ioByteEn0N(ioByteEn0N), .ioByteEn1N(ioByteEn1N), .wideBusMode(wideBusMode));

  // 200 MHz controller clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // host write and read, word wide unless told otherwise
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3,
                    input logic wide = 1'b1);
    logic [15:0] q;
    logic k;
    bitc_host_model_inst.access(1'b1, a, d, be, wide, q, k);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic wide = 1'b1);
    bitc_host_model_inst.access(1'b0, a, 16'h0000, 2'h3, wide, rdata, ok);
  endtask : rd
  // one-cycle engine event, then time for the control word to settle
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : pulse

  // defaults straight after hard reset
  task automatic t_reset;
    `CHK({crcAppend, deferEnable, collisionDetectEnable, netTxEnable}, 4'hF)
    `CHK({txStartAllowed, padEnable, phyLoopback, localLoopback, loopResetNeeded}, 5'h00)
    rd(4'h0);
    `CHK(rdata, bitc_pkg::TCR_RESET)
    rd(4'hE);
    `CHK({rdata[15:8], rdata[2:0]}, {SIG, 3'h0})
  endtask : t_reset

  // every bit set at once; switched mode overrides duplex and carrier monitor
  task automatic t_word;
    wr(4'h0, 16'hFFFF);
    rd(4'h0);
    `CHK(rdata, 16'hFFF7 & bitc_pkg::TCR_WRITE_MASK)
    `CHK({crcAppend, fullDuplexEff, carrierMonEff, deferEnable, collisionDetectEnable}, 5'h08)
    `CHK({acceptOwnFrames, netTxEnable, phyLoopback, localLoopback, padEnable}, 5'h17)
  endtask : t_word

  // byte lanes, eight-bit mode and leaving phy loopback
  task automatic t_lanes;
    wr(4'h0, 16'h0000, 2'h2);
    rd(4'h0);
    `CHK(rdata, 16'h0087)
    `CHK({loopResetNeeded, txStartAllowed}, 2'h2)
    wr(4'h1, 16'h0001, 2'h3, 1'b0);
    rd(4'h1, 1'b0);
    `CHK(rdata[7:0], 8'h01)
    rd(4'h0, 1'b0);
    `CHK(rdata[7:0], 8'h87)
    pulse(configSoftReset);
    rd(4'h0);
    `CHK({loopResetNeeded, rdata}, 17'h00000)
  endtask : t_lanes

  // all eight bank codes; missing banks ignore writes and read signature
  task automatic t_banks;
    wr(4'h0, 16'h0080);
    for (int b = 0; b < 8; b++) begin
      wr(4'hE, 16'(b));
      rd(4'hE);
      `CHK(rdata[2:0], 3'(b))
      wr(4'h0, 16'h0001);
      rd(4'h0);
      `CHK(rdata, (b > 4) ? {SIG, SIG} : (b == 0) ? 16'h0001 : 16'h0000)
    end
    powerDown = 1'b1;
    rd(4'hE);
    `CHK(ok, 1'b0)
    powerDown = 1'b0;
    wr(4'hE, 16'h0000);
    rd(4'h0);
    `CHK(rdata, 16'h0001)
  endtask : t_banks

  // missing carrier aborts without crc and switches the transmitter off
  task automatic t_carrier;
    wr(4'h0, 16'h0401);
    frameActive = 1'b1;
    carrierSense = 1'b0;
    seen = 1'b0;
    @(negedge mclk);
    preambleDone = 1'b1;
    repeat (4) begin
      @(negedge mclk);
      preambleDone = 1'b0;
      seen |= (frameAbortNoCrc === 1'b1 && txHalt === 1'b1);
    end
    frameActive = 1'b0;
    carrierSense = 1'b1;
    rd(4'h0);
    `CHK({seen, txStartAllowed, carrierMonEff, rdata}, 19'h50400)
  endtask : t_carrier

  // force collision self-clears; sqe stop and fatal errors drop transmit enable
  task automatic t_errors;
    wr(4'h0, 16'h0005);
    `CHK(deferEnable, 1'b0)
    pulse(collisionSeen);
    rd(4'h0);
    `CHK({deferEnable, rdata}, 17'h10001)
    pulse(sqeTestFail);
    rd(4'h0);
    `CHK(rdata, 16'h0001)
    wr(4'h0, 16'h1001);
    pulse(sqeTestFail);
    rd(4'h0);
    `CHK(rdata, 16'h1000)
    wr(4'h0, 16'h0801);
    `CHK({acceptOwnFrames, fullDuplexEff}, 2'h3)
    pulse(txFatalError);
    rd(4'h0);
    `CHK(rdata, 16'h0800)
  endtask : t_errors

  // both early transmit methods
  task automatic t_early;
    wr(4'h0, 16'h0000);
    {earlyTxEnable, txDmaAddr, hostPointerAddr} = {1'b1, 11'h101, 11'h100};
    {loadPktNum, txPktNum, loadAddr, txLogicalAddr} = {6'h05, 6'h05, 11'h200, 11'h201};
    repeat (3) @(negedge mclk);
    `CHK({acceptOwnFrames, forceUnderrun}, 2'h1)
    txDmaAddr = 11'h0FF;
    repeat (3) @(negedge mclk);
    `CHK(forceUnderrun, 1'b0)
    wr(4'h0, 16'h4000);
    `CHK(forceUnderrun, 1'b1)
    txPktNum = 6'h06;
    txDmaAddr = 11'h101;
    repeat (3) @(negedge mclk);
    `CHK(forceUnderrun, 1'b0)
  endtask : t_early

  // verdict and end of run
  task automatic wrapUp;
    if (errors == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrapUp

  // main sequence: six cycles of reset, then the scenarios
  initial begin
    {nrst, powerDown, configSoftReset, frameActive, preambleDone, collisionSeen} = 6'h00;
    {sqeTestFail, txFatalError, earlyTxEnable, carrierSense} = 4'h1;
    {txDmaAddr, hostPointerAddr, loadAddr, txLogicalAddr} = 44'h0;
    {loadPktNum, txPktNum} = 12'h000;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    t_reset();
    t_word();
    t_lanes();
    t_banks();
    t_carrier();
    t_errors();
    t_early();
    wrapUp();
  end

  // watchdog, well beyond the roughly four microseconds the scenarios need
  initial begin
    #60000;
    errors++;
    wrapUp();
  end
endmodule : banked_io_tx_control_tb
